/* hw/csp_pkg.sv */
// Package with constants, encodings and carriers for the clock source and prescaler control.
package csp_pkg;

  // ****************************************************************
  // External oscillator type selection encodings
  // ****************************************************************
  localparam logic [2:0] CSP_XSEL_WATCH  = 3'h0;  // 32.768 kHz watch crystal.
  localparam logic [2:0] CSP_XSEL_R04_2  = 3'h1;  // 0.4 to 2 MHz low swing.
  localparam logic [2:0] CSP_XSEL_R2_9   = 3'h2;  // 2 to 9 MHz low swing.
  localparam logic [2:0] CSP_XSEL_R9_12  = 3'h3;  // 9 to 12 MHz low swing.
  localparam logic [2:0] CSP_XSEL_R12_16 = 3'h4;  // 12 to 16 MHz low swing.
  localparam logic [2:0] CSP_XSEL_EXTCLK = 3'h5;  // External clock on the input pin.
  localparam logic [2:0] CSP_XSEL_RST    = 3'h0;  // Reset value of the type field.

  // ****************************************************************
  // PLL input encodings and limits
  // ****************************************************************
  localparam logic [1:0] CSP_PSRC_RC2M   = 2'h0;  // Internal 2 MHz RC.
  localparam logic [1:0] CSP_PSRC_R32M4  = 2'h1;  // Ring oscillator divided by four.
  localparam logic [1:0] CSP_PSRC_CRYSTAL_OSCILLATOR   = 2'h2;  // External crystal oscillator.
  localparam logic [1:0] CSP_PSRC_EXTCLK = 2'h3;  // External clock.
  localparam logic [4:0] CSP_PFAC_MIN    = 5'h01; // Smallest multiplication factor.
  localparam logic [4:0] CSP_PFAC_MAX    = 5'h1f; // Largest multiplication factor.
  localparam logic [4:0] CSP_PFAC_RST    = 5'h01; // Reset multiplication factor.

  // ****************************************************************
  // System clock source encodings
  // ****************************************************************
  localparam logic [2:0] CSP_SCLK_RC2M  = 3'h0;  // Internal 2 MHz RC.
  localparam logic [2:0] CSP_SCLK_RC32K = 3'h1;  // Internal 32 kHz RC.
  localparam logic [2:0] CSP_SCLK_R32M  = 3'h2;  // Internal 32 MHz ring.
  localparam logic [2:0] CSP_SCLK_CRYSTAL_OSCILLATOR  = 3'h3;  // External oscillator.
  localparam logic [2:0] CSP_SCLK_PLL   = 3'h4;  // PLL output.

  // ****************************************************************
  // Prescaler encodings and timing counts
  // ****************************************************************
  localparam logic [3:0] CSP_PSA_RST     = 4'h0;  // Stage A log2 divide, 0 passes.
  localparam logic [3:0] CSP_PSA_MAX     = 4'h9;  // Stage A divides by 512 at most.
  localparam logic [1:0] CSP_PSBC_RST    = 2'h0;  // Stages B and C pass.
  localparam logic [1:0] CSP_PSBC_MAX    = 2'h2;  // Combined B and C divide of four.
  localparam logic [7:0] CSP_SIGNATURE   = 8'hd8; // Protection unlock signature.
  localparam int         CSP_WIN_CYC     = 4;     // Protected window in cycles.
  localparam int         CSP_EXT_START   = 6;     // External clock start-up edges.
  localparam int         CSP_PLL_LOCK    = 64;    // PLL lock in reference cycles.
  localparam int         CSP_XTAL_START  = 16;    // Crystal start-up edges, arbitrary.

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Configuration write request from the CPU.
  typedef struct packed {
    logic       crystal_oscillator_cfg_wr;  // Write oscillator type and low-power bit.
    logic [2:0] crystal_oscillator_sel;     // Oscillator type.
    logic       crystal_oscillator_lpm;     // Watch crystal low-power request.
    logic       pll_cfg_wr;   // Write PLL factor and source.
    logic [4:0] pll_fac;      // PLL factor.
    logic [1:0] pll_src;      // PLL source.
    logic       sclk_wr;      // Write system clock source.
    logic [2:0] sclk_sel;     // System clock source.
    logic       psc_wr;       // Write prescalers.
    logic [3:0] psa;          // Stage A log2 divide.
    logic [1:0] psb;          // Stage B log2 divide.
    logic [1:0] psc;          // Stage C log2 divide.
    logic       lock_wr;      // Set the lock bit.
  } csp_cfg_t;

  // Oscillator readiness inputs from the analog cells.
  typedef struct packed {
    logic rc2m;   // 2 MHz RC ready.
    logic rc32k;  // 32 kHz RC ready.
    logic r32m;   // 32 MHz ring ready.
  } csp_rdy_t;

  // Sleep mode encodings.
  typedef enum logic [2:0] {
    CSP_SLP_IDLE = 3'h0,
    CSP_SLP_PDOWN = 3'h2,
    CSP_SLP_PSAVE = 3'h3,
    CSP_SLP_STBY = 3'h6,
    CSP_SLP_XSTBY = 3'h7,
    CSP_SLP_NONE = 3'h1
  } csp_sleep_t;

  // External oscillator start state, Gray along the path.
  typedef enum logic [1:0] {
    CSP_X_OFF   = 2'b00,
    CSP_X_START = 2'b01,
    CSP_X_READY = 2'b11
  } csp_xst_t;

endpackage

/* hw/csp_clock_ctrl.sv */
// Clock source, PLL and prescaler control with protection, locking and sleep handling.
`timescale 1ns/1ps
module csp_clock_ctrl (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // Protection register write.
  input  wire logic                prot_wr,
  input  wire logic [7:0]          prot_data,
  // Configuration requests.
  input  wire csp_pkg::csp_cfg_t   cfg,
  input  wire logic                ext_osc_enable_bit,
  input  wire logic                pll_enable_bit,
  input  wire logic                fail_det_en,
  // Analog side.
  input  wire csp_pkg::csp_rdy_t   int_rdy,
  input  wire logic                osc_in_edge,
  input  wire logic                ref_edge,
  input  wire logic                ext_fail,
  input  wire logic                rtc_enabled,
  input  wire csp_pkg::csp_sleep_t sleep_mode,
  // Status and control outputs.
  output logic                     ext_osc_ready_flag,
  output logic                     pll_ready_flag,
  output logic                     crystal_oscillator_run,
  output logic                     xtal_amp_en,
  output logic                     watch_crystal_low_power,
  output logic                     pll_run,
  output logic [2:0]               ext_osc_type_select,
  output logic [4:0]               pll_multiply_factor,
  output logic [1:0]               pll_input_select,
  output logic [2:0]               sclk_sel,
  output logic [3:0]               psa_div,
  output logic [1:0]               psb_div,
  output logic [1:0]               psc_div,
  output logic                     int_osc_run,
  output logic                     rtc_osc_run,
  output logic                     cfg_locked,
  output logic                     prot_open,
  output logic                     irq_block,
  output logic                     nmi
);
  import csp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [2:0] xsel_q, xsel_d;          // Oscillator type.
  logic       xlpm_q, xlpm_d;          // Low-power request bit.
  logic       xen_q, xen_d;            // Oscillator enable held.
  csp_xst_t   xst_q, xst_d;            // Oscillator start state.
  logic [4:0] xcnt_q, xcnt_d;          // Start-up edge counter.
  logic [4:0] pfac_q, pfac_d;          // PLL factor.
  logic [1:0] psrc_q, psrc_d;          // PLL source.
  logic       pen_q, pen_d;            // PLL enable held.
  logic [6:0] pcnt_q, pcnt_d;          // PLL lock counter.
  logic       prdy_q, prdy_d;          // PLL ready.
  logic [2:0] sclk_q, sclk_d;          // System clock source.
  logic [3:0] psa_q, psa_d;            // Prescaler A.
  logic [1:0] psb_q, psb_d;            // Prescaler B.
  logic [1:0] psc_q, psc_d;            // Prescaler C.
  logic       lock_q, lock_d;          // Configuration lock.
  logic [2:0] win_q, win_d;            // Protected window counter.
  logic       nmi_q, nmi_d;            // Failure interrupt pulse.
  logic       run_q, run_d;            // Registered run enables.
  logic       irun_q, irun_d;          // Internal oscillators running.
  logic       rrun_q, rrun_d;          // RTC source running.
  logic       amp_q, amp_d;            // Crystal amplifier enable.
  logic       plr_q, plr_d;            // PLL run.
  logic       lpo_q, lpo_d;            // Effective low-power output.

  logic       wo_q, wo_d;              // Window open, registered for the flag outputs.
  logic       is_ext;                  // External clock type selected.
  logic [4:0] start_len;               // Required start-up edges.
  logic       src_rdy;                 // Readiness of the requested source.
  logic       osc_stop;                // Sleep mode stops oscillators.

  // ****************************************************************
  // Combinational next state
  // ****************************************************************
  // Computes every next value from requests, window and lock.
  always_comb
  begin
    is_ext = (xsel_q == CSP_XSEL_EXTCLK);
    // Start-up count, external clock or crystal
    start_len = is_ext ? 5'(CSP_EXT_START) : 5'(CSP_XTAL_START);
    // Sleep stopping modes
    osc_stop = (sleep_mode == CSP_SLP_PDOWN) || (sleep_mode == CSP_SLP_PSAVE);
    xsel_d = xsel_q;
    xlpm_d = xlpm_q;
    xen_d = xen_q;
    xst_d = xst_q;
    xcnt_d = xcnt_q;
    pfac_d = pfac_q;
    psrc_d = psrc_q;
    pen_d = pen_q;
    pcnt_d = pcnt_q;
    prdy_d = prdy_q;
    sclk_d = sclk_q;
    psa_d = psa_q;
    psb_d = psb_q;
    psc_d = psc_q;
    lock_d = lock_q;
    nmi_d = 1'b0;
    // Signature opens window; a consumed write closes it.
    win_d = wo_q ? 3'(win_q - 3'h1) : 3'h0;
    if (prot_wr && (prot_data == CSP_SIGNATURE))
    begin
      win_d = 3'(CSP_WIN_CYC);
    end
    if (cfg.crystal_oscillator_cfg_wr && !xen_q && !lock_q)
    begin
      if (cfg.crystal_oscillator_sel <= CSP_XSEL_EXTCLK)
      begin
        xsel_d = cfg.crystal_oscillator_sel;
      end
      xlpm_d = cfg.crystal_oscillator_lpm;
    end
    if (!lock_q)
    begin
      xen_d = ext_osc_enable_bit;
    end
    if (cfg.pll_cfg_wr && !pen_q && !lock_q)
    begin
      if ((cfg.pll_fac >= CSP_PFAC_MIN) && (cfg.pll_fac <= CSP_PFAC_MAX))
      begin
        pfac_d = cfg.pll_fac;
      end
      if (!((cfg.pll_src == CSP_PSRC_CRYSTAL_OSCILLATOR) && (xsel_q == CSP_XSEL_WATCH)))
      begin
        psrc_d = cfg.pll_src;
      end
    end
    if (!lock_q)
    begin
      pen_d = pll_enable_bit;
    end
    case (xst_q)
      CSP_X_OFF:
      begin
        xcnt_d = 5'h00;
        if (xen_q && !osc_stop)
        begin
          xst_d = CSP_X_START;
        end
      end
      CSP_X_START:
      begin
        if (!xen_q || osc_stop)
        begin
          xst_d = CSP_X_OFF;
        end
        else if (osc_in_edge)
        begin
          xcnt_d = 5'(xcnt_q + 5'h01);
          if (5'(xcnt_q + 5'h01) >= start_len)
          begin
            xst_d = CSP_X_READY;
          end
        end
      end
      CSP_X_READY:
      begin
        if (!xen_q || osc_stop)
        begin
          xst_d = CSP_X_OFF;
        end
      end
      default:
      begin
        xst_d = CSP_X_OFF;
      end
    endcase
    if (!pen_q || osc_stop)
    begin
      pcnt_d = 7'h00;
      prdy_d = 1'b0;
    end
    else if (ref_edge && !prdy_q)
    begin
      pcnt_d = 7'(pcnt_q + 7'h01);
      if (7'(pcnt_q + 7'h01) >= 7'(CSP_PLL_LOCK))
      begin
        prdy_d = 1'b1;
      end
    end
    // Readiness of the requested system source.
    case (cfg.sclk_sel)
      CSP_SCLK_RC2M:  src_rdy = int_rdy.rc2m;
      CSP_SCLK_RC32K: src_rdy = int_rdy.rc32k;
      CSP_SCLK_R32M:  src_rdy = int_rdy.r32m;
      CSP_SCLK_CRYSTAL_OSCILLATOR:  src_rdy = (xst_q == CSP_X_READY);
      CSP_SCLK_PLL:   src_rdy = prdy_q;
      default:        src_rdy = 1'b0;
    endcase
    if (wo_q && !lock_q && cfg.psc_wr)
    begin
      if ((cfg.psa <= CSP_PSA_MAX) && (3'(cfg.psb) + 3'(cfg.psc) <= 3'(CSP_PSBC_MAX)))
      begin
        psa_d = cfg.psa;
        psb_d = cfg.psb;
        psc_d = cfg.psc;
      end
      win_d = 3'h0;
    end
    else if (wo_q && !lock_q && cfg.sclk_wr)
    begin
      if (src_rdy)
      begin
        sclk_d = cfg.sclk_sel;
      end
      win_d = 3'h0;
    end
    else if (wo_q && cfg.lock_wr)
    begin
      lock_d = 1'b1;
      win_d = 3'h0;
    end
    if (fail_det_en && ext_fail && xen_q)
    begin
      lock_d = 1'b0;
      nmi_d = 1'b1;
      xen_d = 1'b0;
      xst_d = CSP_X_OFF;
      if (sclk_q == CSP_SCLK_CRYSTAL_OSCILLATOR || (sclk_q == CSP_SCLK_PLL && psrc_q[1]))
      begin
        sclk_d = CSP_SCLK_RC2M;
      end
    end
    irun_d = !osc_stop;
    rrun_d = !osc_stop || ((sleep_mode == CSP_SLP_PSAVE) && rtc_enabled);
    run_d = xen_d && !osc_stop;
    amp_d = run_d && !(xsel_d == CSP_XSEL_EXTCLK);
    plr_d = pen_d && !osc_stop;
    lpo_d = xlpm_d && (xsel_d == CSP_XSEL_WATCH);
    wo_d = (win_d != 3'h0);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // reset selects RC, undivided
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      xsel_q <= CSP_XSEL_RST;
      xlpm_q <= 1'b0;
      xen_q  <= 1'b0;
      xst_q  <= CSP_X_OFF;
      xcnt_q <= 5'h00;
      pfac_q <= CSP_PFAC_RST;
      psrc_q <= CSP_PSRC_RC2M;
      pen_q  <= 1'b0;
      pcnt_q <= 7'h00;
      prdy_q <= 1'b0;
      sclk_q <= CSP_SCLK_RC2M;
      psa_q  <= CSP_PSA_RST;
      psb_q  <= CSP_PSBC_RST;
      psc_q  <= CSP_PSBC_RST;
      lock_q <= 1'b0;
      win_q  <= 3'h0;
      nmi_q  <= 1'b0;
      run_q  <= 1'b0;
      irun_q <= 1'b1;
      rrun_q <= 1'b1;
      amp_q  <= 1'b0;
      plr_q  <= 1'b0;
      lpo_q  <= 1'b0;
      wo_q   <= 1'b0;
    end
    else
    begin
      xsel_q <= xsel_d;
      xlpm_q <= xlpm_d;
      xen_q  <= xen_d;
      xst_q  <= xst_d;
      xcnt_q <= xcnt_d;
      pfac_q <= pfac_d;
      psrc_q <= psrc_d;
      pen_q  <= pen_d;
      pcnt_q <= pcnt_d;
      prdy_q <= prdy_d;
      sclk_q <= sclk_d;
      psa_q  <= psa_d;
      psb_q  <= psb_d;
      psc_q  <= psc_d;
      lock_q <= lock_d;
      win_q  <= win_d;
      nmi_q  <= nmi_d;
      run_q  <= run_d;
      irun_q <= irun_d;
      rrun_q <= rrun_d;
      amp_q  <= amp_d;
      plr_q  <= plr_d;
      lpo_q  <= lpo_d;
      wo_q   <= wo_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a flip-flop.
  assign ext_osc_ready_flag      = xst_q[1];
  assign pll_ready_flag          = prdy_q;
  assign crystal_oscillator_run                = run_q;
  assign xtal_amp_en             = amp_q;
  assign watch_crystal_low_power = lpo_q;
  assign pll_run                 = plr_q;
  assign ext_osc_type_select     = xsel_q;
  assign pll_multiply_factor     = pfac_q;
  assign pll_input_select        = psrc_q;
  assign sclk_sel                = sclk_q;
  assign psa_div                 = psa_q;
  assign psb_div                 = psb_q;
  assign psc_div                 = psc_q;
  assign int_osc_run             = irun_q;
  assign rtc_osc_run             = rrun_q;
  assign cfg_locked              = lock_q;
  assign prot_open               = wo_q;
  assign irq_block               = wo_q;
  assign nmi                     = nmi_q;

endmodule

/* dv/csp_clock_props.sv */
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/1ps
module csp_clock_props (
  // Clock and reset.
  input wire logic                sys_clk,
  input wire logic                resetn,
  // Requests and analog side.
  input wire logic                prot_wr,
  input wire logic [7:0]          prot_data,
  input wire logic                ext_osc_enable_bit,
  input wire logic                pll_enable_bit,
  input wire logic                fail_det_en,
  input wire logic                osc_in_edge,
  input wire logic                ref_edge,
  input wire logic                ext_fail,
  input wire csp_pkg::csp_sleep_t sleep_mode,
  // Outputs under watch.
  input wire logic                ext_osc_ready_flag,
  input wire logic                pll_ready_flag,
  input wire logic                crystal_oscillator_run,
  input wire logic                xtal_amp_en,
  input wire logic                watch_crystal_low_power,
  input wire logic                pll_run,
  input wire logic [2:0]          ext_osc_type_select,
  input wire logic [4:0]          pll_multiply_factor,
  input wire logic [1:0]          pll_input_select,
  input wire logic [2:0]          sclk_sel,
  input wire logic [3:0]          psa_div,
  input wire logic [1:0]          psb_div,
  input wire logic [1:0]          psc_div,
  input wire logic                int_osc_run,
  input wire logic                rtc_osc_run,
  input wire logic                cfg_locked,
  input wire logic                prot_open,
  input wire logic                irq_block,
  input wire logic                nmi
);
  import csp_pkg::*;
  // ****************************************************************
  // Sequences and assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // A signature write opens the protected window.
  sequence sig_wr;
    prot_wr && prot_data == CSP_SIGNATURE;
  endsequence
  // A detected failure while the oscillator runs.
  sequence fail_hit;
    fail_det_en && $rose(ext_fail) && crystal_oscillator_run && $past(ext_osc_enable_bit);
  endsequence
  win_open_a: assert property (sig_wr |=> prot_open && irq_block)
    else $error("window did not open");
  psc_win_a: assert property ($changed({psa_div, psb_div, psc_div}) |-> $past(prot_open))
    else $error("prescaler changed outside window");
  div_range_a: assert property (psa_div <= CSP_PSA_MAX && 3'(psb_div) + 3'(psc_div) <= 3'h2)
    else $error("prescaler out of range");
  lock_hold_a: assert property (cfg_locked && !ext_fail |=> $stable({psa_div, psb_div, psc_div}))
    else $error("locked prescaler changed");
  sclk_rdy_a: assert property ($changed(sclk_sel) && sclk_sel != CSP_SCLK_RC2M |->
    (sclk_sel == CSP_SCLK_CRYSTAL_OSCILLATOR) ? $past(ext_osc_ready_flag) :
    (sclk_sel == CSP_SCLK_PLL) ? $past(pll_ready_flag) : 1'b1)
    else $error("switched to unready source");
  ext_rdy_a: assert property ($rose(ext_osc_ready_flag) |-> $past(osc_in_edge) && $past(crystal_oscillator_run))
    else $error("oscillator ready without input edge");
  pll_rdy_a: assert property ($rose(pll_ready_flag) |-> $past(ref_edge) && $past(pll_run))
    else $error("pll ready without reference edge");
  pll_frz_a: assert property ($past(pll_enable_bit) |=> $stable({pll_multiply_factor, pll_input_select}))
    else $error("pll setup changed while enabled");
  crystal_oscillator_frz_a: assert property ($past(ext_osc_enable_bit) && !fail_det_en |=> $stable(ext_osc_type_select))
    else $error("oscillator type changed while enabled");
  lpm_type_a: assert property (watch_crystal_low_power |-> ext_osc_type_select == CSP_XSEL_WATCH)
    else $error("low power outside watch mode");
  amp_type_a: assert property (xtal_amp_en |-> crystal_oscillator_run && ext_osc_type_select != CSP_XSEL_EXTCLK)
    else $error("amplifier on with clock input");
  sleep_stop_a: assert property ((sleep_mode == CSP_SLP_PDOWN) [*2] |-> !int_osc_run && !rtc_osc_run)
    else $error("oscillator runs in power down");
  fail_nmi_a: assert property (fail_hit |=> nmi && !cfg_locked)
    else $error("failure did not unlock or raise nmi");
endmodule

/* dv/csp_osc_model.sv */
// Model of the external clock signal feeding the oscillator pin and the PLL reference.
`timescale 1ns/1ps
module csp_osc_model #(
  parameter int PERIOD = 4  // Cycles between input edges; larger is a slower source.
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Run requests from the block.
  input  wire logic crystal_oscillator_run,
  input  wire logic pll_run,
  // Edge pulses toward the block.
  output logic      osc_in_edge,
  output logic      ref_edge
);
  logic [7:0] cnt_q;  // Period counter.
  // Edges appear only while running, so the source stands still otherwise.
  // fixed steady period
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q       <= 8'h00;
      osc_in_edge <= 1'b0;
      ref_edge    <= 1'b0;
    end
    else
    begin
      cnt_q       <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      osc_in_edge <= crystal_oscillator_run && cnt_q == 8'h00;
      ref_edge    <= pll_run && cnt_q[0];
    end
  end
endmodule

/* dv/system_clock_source_pll_prescaler_tb.sv */
// Self-checking bench for the clock source, PLL and prescaler control.
`timescale 1ns/1ps
module system_clock_source_pll_prescaler_tb;
  import csp_pkg::*;
  typedef struct {int k; logic [31:0] v;} csp_note_t;
  logic       sys_clk = 1'b0;
  logic       resetn, prot_wr, ext_osc_enable_bit, pll_enable_bit, fail_det_en;
  logic       osc_in_edge, ref_edge, ext_fail, rtc_enabled;
  logic [7:0] prot_data;
  csp_cfg_t   cfg;
  csp_rdy_t   int_rdy;
  csp_sleep_t sleep_mode;
  logic       ext_osc_ready_flag, pll_ready_flag, crystal_oscillator_run, xtal_amp_en, pll_run;
  logic       watch_crystal_low_power, int_osc_run, rtc_osc_run, cfg_locked;
  logic       prot_open, irq_block, nmi;
  logic [2:0] ext_osc_type_select, sclk_sel;
  logic [4:0] pll_multiply_factor, f;
  logic [1:0] pll_input_select, psb_div, psc_div, b, c;
  logic [3:0] psa_div, a;
  csp_note_t  q[$];
  csp_note_t  cur;
  event       look;
  int         err_total = 0;
  int         n_tests = 0;
  csp_sleep_t md[7] = '{CSP_SLP_PDOWN, CSP_SLP_PSAVE, CSP_SLP_PSAVE, CSP_SLP_STBY,
                        CSP_SLP_XSTBY, CSP_SLP_IDLE, CSP_SLP_NONE};
  logic [1:0] rn[7] = '{2'b00, 2'b01, 2'b00, 2'b11, 2'b11, 2'b11, 2'b11};

  csp_clock_ctrl dut (.sys_clk, .resetn, .prot_wr, .prot_data, .cfg, .ext_osc_enable_bit,
    .pll_enable_bit, .fail_det_en, .int_rdy, .osc_in_edge, .ref_edge, .ext_fail, .rtc_enabled,
    .sleep_mode, .ext_osc_ready_flag, .pll_ready_flag, .crystal_oscillator_run, .xtal_amp_en,
    .watch_crystal_low_power, .pll_run, .ext_osc_type_select, .pll_multiply_factor,
    .pll_input_select, .sclk_sel, .psa_div, .psb_div, .psc_div, .int_osc_run, .rtc_osc_run,
    .cfg_locked, .prot_open, .irq_block, .nmi);
  csp_osc_model #(.PERIOD(4)) u_osc (.sys_clk, .resetn, .crystal_oscillator_run, .pll_run, .osc_in_edge,
    .ref_edge);

  // 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  // ****************************************************************
  // Driver helpers and result checking
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Records an expected result and wakes the monitor.
  task automatic note(input int k, input logic [31:0] v);
    q.push_back('{k, v});
    -> look;
  endtask
  // Lets the request edge pass and drops every write strobe.
  task automatic fire();
    cyc(1);
    cfg = '0;
  endtask
  task automatic unlock();
    prot_wr   = 1'b1;
    prot_data = CSP_SIGNATURE;
    cyc(1);
    prot_wr   = 1'b0;
  endtask
  task automatic psw(input logic [3:0] pa, input logic [1:0] pb, pc);
    unlock();
    cfg.psc_wr = 1'b1;
    {cfg.psa, cfg.psb, cfg.psc} = {pa, pb, pc};
    fire();
  endtask
  task automatic scw(input logic [2:0] s);
    unlock();
    cfg.sclk_wr  = 1'b1;
    cfg.sclk_sel = s;
    fire();
  endtask
  task automatic xw(input logic [2:0] t);
    cfg.crystal_oscillator_cfg_wr = 1'b1;
    cfg.crystal_oscillator_sel    = t;
    cfg.crystal_oscillator_lpm    = 1'b1;
    fire();
  endtask
  task automatic pw(input logic [4:0] pf, input logic [1:0] ps);
    cfg.pll_cfg_wr = 1'b1;
    {cfg.pll_fac, cfg.pll_src} = {pf, ps};
    fire();
  endtask
  // Waits for n edge pulses, then for the resulting outputs to settle.
  task automatic edges(ref logic s, input int n);
    repeat (n) @(posedge sys_clk iff s);
    cyc(1);
  endtask
  function automatic logic [31:0] obs(input int k);
    case (k)
      0: obs = {psa_div, psb_div, psc_div};
      1: obs = sclk_sel;
      2: obs = {ext_osc_ready_flag, pll_ready_flag};
      3: obs = {pll_multiply_factor, pll_input_select};
      4: obs = ext_osc_type_select;
      5: obs = watch_crystal_low_power;
      6: obs = {cfg_locked, nmi};
      7: obs = {int_osc_run, rtc_osc_run};
      default: obs = prot_open;
    endcase
  endfunction
  task automatic chk(input logic [31:0] exp_v, input logic [31:0] got);
    n_tests++;
    if (got !== exp_v)
    begin
      err_total++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp_v, got);
    end
  endtask
  // Monitor takes the oldest note each time a result appears.
  always @(look)
    while (q.size() > 0)
    begin
      cur = q.pop_front();
      chk(cur.v, obs(cur.k));
    end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The tests need about 250 cycles; the watchdog allows far more.
  initial
  begin
    #(20 * 20000);
    err_total++;
    finish_test();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    {resetn, prot_wr, ext_osc_enable_bit, pll_enable_bit, fail_det_en} = '0;
    {ext_fail, rtc_enabled, prot_data, cfg} = '0;
    int_rdy    = '1;
    sleep_mode = CSP_SLP_NONE;
    void'($urandom(50301));
    cyc(6);
    resetn = 1'b1;
    note(0, 8'h00);
    note(1, CSP_SCLK_RC2M);
    $display("reset values done");
    cfg.psc_wr = 1'b1;
    cfg.psa    = 4'h3;
    fire();
    note(0, 8'h00);
    repeat (6)
    begin
      a = 4'($urandom_range(9));
      b = 2'($urandom_range(2));
      c = 2'($urandom_range(2 - b));
      psw(a, b, c);
      note(0, {a, b, c});
    end
    psw(4'h9, 2'h0, 2'h2);
    note(0, 8'h92);
    psw(4'ha, 2'h0, 2'h0);
    note(0, 8'h92);
    psw(4'h1, 2'h2, 2'h1);
    note(0, 8'h92);
    unlock();
    cyc(4);
    note(8, 1'b0);
    cfg.psc_wr = 1'b1;
    fire();
    note(0, 8'h92);
    psw(4'h0, 2'h0, 2'h0);
    cfg.sclk_wr  = 1'b1;
    cfg.sclk_sel = CSP_SCLK_RC32K;
    fire();
    note(1, CSP_SCLK_RC2M);
    scw(CSP_SCLK_RC32K);
    note(1, CSP_SCLK_RC32K);
    int_rdy.r32m = 1'b0;
    scw(CSP_SCLK_R32M);
    note(1, CSP_SCLK_RC32K);
    scw(CSP_SCLK_RC2M);
    $display("prescaler and window done");
    xw(CSP_XSEL_WATCH);
    note(5, 1'b1);
    pw(5'h01, CSP_PSRC_CRYSTAL_OSCILLATOR);
    note(3, {5'h01, CSP_PSRC_RC2M});
    for (int t = 1; t < 6; t++)
    begin
      xw(3'(t));
      note(4, t);
    end
    note(5, 1'b0);
    xw(3'h6);
    note(4, CSP_XSEL_EXTCLK);
    ext_osc_enable_bit = 1'b1;
    edges(osc_in_edge, 5);
    note(2, 2'b00);
    edges(osc_in_edge, 1);
    note(2, 2'b10);
    xw(CSP_XSEL_R04_2);
    note(4, CSP_XSEL_EXTCLK);
    scw(CSP_SCLK_CRYSTAL_OSCILLATOR);
    note(1, CSP_SCLK_CRYSTAL_OSCILLATOR);
    $display("external clock done");
    for (int s = 0; s < 4; s++)
    begin
      f = 5'($urandom_range(31, 1));
      pw(f, 2'(s));
      note(3, {f, 2'(s)});
    end
    pw(CSP_PFAC_MAX, CSP_PSRC_RC2M);
    pw(5'h00, CSP_PSRC_RC2M);
    note(3, {CSP_PFAC_MAX, CSP_PSRC_RC2M});
    pll_enable_bit = 1'b1;
    edges(ref_edge, 63);
    note(2, 2'b10);
    edges(ref_edge, 1);
    note(2, 2'b11);
    pw(5'h02, CSP_PSRC_R32M4);
    note(3, {CSP_PFAC_MAX, CSP_PSRC_RC2M});
    scw(CSP_SCLK_PLL);
    note(1, CSP_SCLK_PLL);
    scw(CSP_SCLK_CRYSTAL_OSCILLATOR);
    $display("pll done");
    unlock();
    cfg.lock_wr = 1'b1;
    fire();
    note(6, 2'b10);
    psw(4'h1, 2'h0, 2'h0);
    note(0, 8'h00);
    fail_det_en = 1'b1;
    ext_fail    = 1'b1;
    cyc(1);
    ext_fail           = 1'b0;
    ext_osc_enable_bit = 1'b0;
    note(6, 2'b01);
    note(1, CSP_SCLK_RC2M);
    cyc(1);
    note(6, 2'b00);
    $display("lock and failure done");
    for (int i = 0; i < 7; i++)
    begin
      rtc_enabled = (i == 1);
      sleep_mode  = md[i];
      cyc(2);
      note(7, rn[i]);
    end
    $display("sleep modes done");
    pll_enable_bit = 1'b0;
    resetn         = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(1);
    note(3, {CSP_PFAC_RST, CSP_PSRC_RC2M});
    note(6, 2'b00);
    $display("second reset done");
    cyc(1);
    finish_test();
  end
endmodule

bind csp_clock_ctrl csp_clock_props u_props (.sys_clk, .resetn, .prot_wr, .prot_data,
  .ext_osc_enable_bit, .pll_enable_bit, .fail_det_en, .osc_in_edge, .ref_edge, .ext_fail,
  .sleep_mode, .ext_osc_ready_flag, .pll_ready_flag, .crystal_oscillator_run, .xtal_amp_en,
  .watch_crystal_low_power, .pll_run, .ext_osc_type_select, .pll_multiply_factor,
  .pll_input_select, .sclk_sel, .psa_div, .psb_div, .psc_div, .int_osc_run, .rtc_osc_run,
  .cfg_locked, .prot_open, .irq_block, .nmi);
